// >>> shared/timer_pkg.sv
// Constants shared by the two-channel timer PWM block
package timer_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_MODULO = 8'h08;
   localparam logic [7:0] OFF_CH0_CTRL = 8'h0C;
   localparam logic [7:0] OFF_CH0_VAL = 8'h10;
   localparam logic [7:0] OFF_CH1_CTRL = 8'h14;
   localparam logic [7:0] OFF_CH1_VAL = 8'h18;
   localparam logic [7:0] OFF_BREAK = 8'h1C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int OVF_BIT = 7;
   localparam int OVF_IE_BIT = 6;
   localparam int STOP_BIT = 5;
   localparam int RST_BIT = 4;
   localparam int PS_MSB = 2;
   localparam int FLAG_BIT = 7;
   localparam int IE_BIT = 6;
   localparam int BUF_BIT = 5;
   localparam int MSA_BIT = 4;
   localparam int ACT_HI_BIT = 3;
   localparam int ACT_LO_BIT = 2;
   localparam int TOV_BIT = 1;
   localparam int MAX_BIT = 0;
   localparam int BCE_BIT = 0;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [15:0] MODULO_RST = 16'hFFFF;
   localparam logic STOP_RST = 1'b1;
   localparam logic [2:0] PS_EXT = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

endpackage

// >>> shared/presc_if.sv
// Link between the timer core and its prescaler
`timescale 1ns/1ps
interface presc_if;
   logic [2:0] sel;
   logic clear;
   logic run;
   logic ext_level;
   logic tick;

   modport ctrl (output sel, output clear, output run, output ext_level, input tick);
   modport div (input sel, input clear, input run, input ext_level, output tick);
endinterface

// >>> src/timer_prescaler.sv
// Counter clock prescaler with external clock edge option
`timescale 1ns/1ps
module timer_prescaler #(
   parameter int DIV_W = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   presc_if.div pif
);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic ext_prev;
   } presc_state_s;

   presc_state_s q;
   presc_state_s d;

   // Low bits that must all be ones for a divided tick
   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
      logic [DIV_W:0] one;
      one = (DIV_W+1)'(1);
      div_mask = DIV_W'((one << sel) - one);
   endfunction

   // Tick generation and divider advance
   always_comb begin
      d = q;
      pif.tick = 1'b0;
      d.ext_prev = pif.ext_level;
      if (pif.run) begin
         if (pif.sel == timer_pkg::PS_EXT) begin
            pif.tick = pif.ext_level && !q.ext_prev;
         end else begin
            pif.tick = (q.div & div_mask(pif.sel)) == div_mask(pif.sel);
         end
         d.div = q.div + DIV_W'(1);
      end
      if (pif.clear) begin
         d.div = '0;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_div_two_rate: assert property ((pif.run && pif.sel == 3'h1 && pif.tick) |=> !pif.tick)
      else $error("Divide by two ticked twice in a row");
   chk_ext_edge_only: assert property ((pif.tick && pif.sel == 3'h7) |-> (pif.ext_level && !q.ext_prev))
      else $error("External tick without rising pin edge");

endmodule // timer_prescaler

// >>> src/two_channel_timer_pwm.sv
// Two-channel timer with PWM, compare, capture and an AXI4-Lite register slave
//
// Overview of operation
// - Compare only when counter equals pulse value
// - Channel compare event at pulse end
// - Overflow event at end of period
// - Buffered bit links channels onto channel 0 pin
// - Last written pair becomes active at overflow
// - Linked: channel 1 control unused, pin released
// - Writing active pair takes effect immediately
// - Buffered bit outranks mode select A
// - No overflow toggle gives zero duty
// - Max duty plus overflow toggle gives full duty
// - Overflow flag on wrap, gated request
// - Channel flag on capture or compare, gated request
// - Wait mode counts, blocks access, request wakes
// - Stop mode freezes prescaler, counter, compares and captures (bus and counter reset write still act), resumes afterwards
// - Break freezes counter and blocks captures
// - Break clear enable lets flags clear
// - Break without enable protects flags, two-step survives
// - Prescaler code seven counts external pin rising edges
// - External clock selected forces pin input
// - Codes zero to six divide bus clock
// - Overflow flag clears by armed read then zero
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module two_channel_timer_pwm (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic break_active,
   input wire logic ext_timer_clock_pin,
   input wire logic chan0_pin_in,
   output logic chan0_pin_out,
   output logic chan0_pin_oe,
   input wire logic chan1_pin_in,
   output logic chan1_pin_out,
   output logic chan1_pin_oe,
   output logic ext_clock_as_input,
   output logic irq_request
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic flag;
      logic armed;
      logic irq_en;
      logic buf_mode;
      logic mode_a;
      logic act_hi;
      logic act_lo;
      logic tov;
      logic max_duty;
      logic [15:0] value;
      logic pin;
   } chan_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] modulo;
      logic [2:0] ps;
      logic stop;
      logic ovf_flag;
      logic ovf_armed;
      logic ovf_ie;
      logic bce;
      logic active_sel;
      logic pending_sel;
      chan_s [1:0] ch;
      logic [1:0] prev_in;
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic awready;
      logic wready;
      logic arready;
      logic irq;
      logic [1:0] pin_out;
      logic [1:0] pin_oe;
      logic ext_in;
   } state_s;

   state_s q;
   state_s d;

   presc_if pif ();

   logic wr_do;
   logic rd_do;
   logic trst_wr;
   logic flag_lock;
   logic linked;
   logic ovf_ev;
   logic [15:0] cnt_next;
   logic [15:0] act_val0;
   logic [1:0] pin_in;
   logic [1:0] chan_on;
   logic [1:0][15:0] val;
   logic [1:0] out_mode;
   logic [1:0] cmp_ev;
   logic [1:0] cap_ev;

   // ****************************************
   // Helper functions
   // ****************************************

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = data[15:8];
      end
   endfunction

   // Channel control write with armed flag clear
   function automatic chan_s ctrl_write(input chan_s c, input logic [7:0] v, input logic lock);
      chan_s r;
      r = c;
      r.irq_en = v[timer_pkg::IE_BIT];
      r.buf_mode = v[timer_pkg::BUF_BIT];
      r.mode_a = v[timer_pkg::MSA_BIT];
      r.act_hi = v[timer_pkg::ACT_HI_BIT];
      r.act_lo = v[timer_pkg::ACT_LO_BIT];
      r.tov = v[timer_pkg::TOV_BIT];
      r.max_duty = v[timer_pkg::MAX_BIT];
      if (!v[timer_pkg::FLAG_BIT] && c.armed && !lock) begin
         r.flag = 1'b0;
         r.armed = 1'b0;
      end
      return r;
   endfunction

   // Channel control read image
   function automatic logic [31:0] ctrl_read(input chan_s c);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[timer_pkg::FLAG_BIT] = c.flag;
      r[timer_pkg::IE_BIT] = c.irq_en;
      r[timer_pkg::BUF_BIT] = c.buf_mode;
      r[timer_pkg::MSA_BIT] = c.mode_a;
      r[timer_pkg::ACT_HI_BIT] = c.act_hi;
      r[timer_pkg::ACT_LO_BIT] = c.act_lo;
      r[timer_pkg::TOV_BIT] = c.tov;
      r[timer_pkg::MAX_BIT] = c.max_duty;
      return r;
   endfunction

   // ****************************************
   // Prescaler and counter events
   // ****************************************

   // Prescaler hookup, frozen by stop bit, stop mode or break
   assign pif.sel = q.ps;
   assign pif.clear = trst_wr;
   assign pif.run = !q.stop && !stop_mode && !break_active;
   assign pif.ext_level = ext_timer_clock_pin;

   timer_prescaler #(
      .DIV_W(6)
   ) u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .pif(pif)
   );

   // Bus side strobes
   assign wr_do = q.aw_full && q.w_full && !q.bvalid;
   assign rd_do = arvalid && q.arready;
   assign trst_wr = wr_do && !wait_mode && q.awaddr == timer_pkg::OFF_STATUS && q.wstrb[0]
                    && q.wdata[timer_pkg::RST_BIT];
   assign flag_lock = break_active && !q.bce;

   // Counter wrap and overflow event
   assign cnt_next = (q.cnt == q.modulo) ? 16'h0000 : q.cnt + timer_pkg::COUNT_ONE;
   assign ovf_ev = pif.tick && !trst_wr && q.cnt == q.modulo;

   // Linked pair picks the active value register
   assign linked = q.ch[0].buf_mode;
   assign act_val0 = (linked && q.active_sel) ? q.ch[1].value : q.ch[0].value;
   assign chan_on = {!linked, 1'b1};
   assign val[0] = act_val0;
   assign val[1] = q.ch[1].value;
   assign pin_in = {chan1_pin_in, chan0_pin_in};

   // Per-channel compare and capture detection
   for (genvar i = 0; i < 2; i++) begin : g_chan
      assign out_mode[i] = chan_on[i] && (q.ch[i].mode_a || q.ch[i].buf_mode);
      assign cmp_ev[i] = pif.tick && !trst_wr && out_mode[i] && cnt_next == val[i];
      assign cap_ev[i] = chan_on[i] && !out_mode[i] && pif.run
                         && ((pin_in[i] && !q.prev_in[i] && q.ch[i].act_lo)
                         || (!pin_in[i] && q.prev_in[i] && q.ch[i].act_hi));
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      d = q;
      d.prev_in = pin_in;

      // Address and data channels taken independently
      if (awvalid && q.awready) begin
         d.aw_full = 1'b1;
         d.awaddr = awaddr;
      end
      if (wvalid && q.wready) begin
         d.w_full = 1'b1;
         d.wdata = wvalid ? wdata : q.wdata;
         d.wstrb = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end

      // Register writes, refused in wait mode
      if (wr_do) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = timer_pkg::RESP_OKAY;
         if (wait_mode) begin
            d.bresp = timer_pkg::RESP_SLVERR;
         end else begin
            case (q.awaddr)
               timer_pkg::OFF_STATUS: begin
                  if (q.wstrb[0]) begin
                     d.ovf_ie = q.wdata[timer_pkg::OVF_IE_BIT];
                     d.stop = q.wdata[timer_pkg::STOP_BIT];
                     d.ps = q.wdata[timer_pkg::PS_MSB:0];
                     if (!q.wdata[timer_pkg::OVF_BIT] && q.ovf_armed && !flag_lock) begin
                        d.ovf_flag = 1'b0;
                        d.ovf_armed = 1'b0;
                     end
                  end
               end
               timer_pkg::OFF_COUNT: begin
               end
               timer_pkg::OFF_MODULO: d.modulo = merge16(q.modulo, q.wdata, q.wstrb);
               timer_pkg::OFF_CH0_CTRL: begin
                  if (q.wstrb[0]) begin
                     d.ch[0] = ctrl_write(q.ch[0], q.wdata[7:0], flag_lock);
                  end
               end
               timer_pkg::OFF_CH0_VAL: begin
                  d.ch[0].value = merge16(q.ch[0].value, q.wdata, q.wstrb);
                  d.pending_sel = 1'b0;
               end
               timer_pkg::OFF_CH1_CTRL: begin
                  if (q.wstrb[0] && !linked) begin
                     d.ch[1] = ctrl_write(q.ch[1], q.wdata[7:0], flag_lock);
                     d.ch[1].buf_mode = 1'b0;
                  end
               end
               timer_pkg::OFF_CH1_VAL: begin
                  d.ch[1].value = merge16(q.ch[1].value, q.wdata, q.wstrb);
                  d.pending_sel = 1'b1;
               end
               timer_pkg::OFF_BREAK: begin
                  if (q.wstrb[0]) begin
                     d.bce = q.wdata[timer_pkg::BCE_BIT];
                  end
               end
               default: d.bresp = timer_pkg::RESP_SLVERR;
            endcase
         end
      end

      // Register reads, first step of flag clear
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (rd_do) begin
         d.rvalid = 1'b1;
         d.rresp = timer_pkg::RESP_OKAY;
         d.rdata = 32'h0000_0000;
         if (wait_mode) begin
            d.rresp = timer_pkg::RESP_SLVERR;
         end else begin
            case (araddr)
               timer_pkg::OFF_STATUS: begin
                  d.rdata[timer_pkg::OVF_BIT] = q.ovf_flag;
                  d.rdata[timer_pkg::OVF_IE_BIT] = q.ovf_ie;
                  d.rdata[timer_pkg::STOP_BIT] = q.stop;
                  d.rdata[timer_pkg::PS_MSB:0] = q.ps;
                  if (q.ovf_flag && !flag_lock) begin
                     d.ovf_armed = 1'b1;
                  end
               end
               timer_pkg::OFF_COUNT: d.rdata[15:0] = q.cnt;
               timer_pkg::OFF_MODULO: d.rdata[15:0] = q.modulo;
               timer_pkg::OFF_CH0_CTRL: begin
                  d.rdata = ctrl_read(q.ch[0]);
                  if (q.ch[0].flag && !flag_lock) begin
                     d.ch[0].armed = 1'b1;
                  end
               end
               timer_pkg::OFF_CH0_VAL: d.rdata[15:0] = q.ch[0].value;
               timer_pkg::OFF_CH1_CTRL: begin
                  d.rdata = ctrl_read(q.ch[1]);
                  if (q.ch[1].flag && !flag_lock && !linked) begin
                     d.ch[1].armed = 1'b1;
                  end
               end
               timer_pkg::OFF_CH1_VAL: d.rdata[15:0] = q.ch[1].value;
               timer_pkg::OFF_BREAK: d.rdata[timer_pkg::BCE_BIT] = q.bce;
               default: d.rresp = timer_pkg::RESP_SLVERR;
            endcase
         end
      end

      // Counter advance, counter reset has priority
      if (trst_wr) begin
         d.cnt = 16'h0000;
      end else if (pif.tick) begin
         d.cnt = cnt_next;
      end

      // Overflow flag, set wins over a pending clear
      if (ovf_ev) begin
         d.ovf_flag = 1'b1;
         d.ovf_armed = 1'b0;
      end

      // Buffered pair swap at period start
      if (!linked) begin
         d.active_sel = 1'b0;
         d.pending_sel = 1'b0;
      end else if (ovf_ev) begin
         d.active_sel = q.pending_sel;
      end

      // Channel flags, captures and pin levels
      for (int i = 0; i < 2; i++) begin
         if (cmp_ev[i] || cap_ev[i]) begin
            d.ch[i].flag = 1'b1;
            d.ch[i].armed = 1'b0;
         end
         if (cap_ev[i]) begin
            d.ch[i].value = q.cnt;
         end
         if (q.ch[i].max_duty && q.ch[i].tov) begin
            d.ch[i].pin = !q.ch[i].act_lo;
         end else begin
            if (ovf_ev && q.ch[i].tov) begin
               d.ch[i].pin = !q.ch[i].pin;
            end
            if (cmp_ev[i]) begin
               case ({q.ch[i].act_hi, q.ch[i].act_lo})
                  2'b01: d.ch[i].pin = !d.ch[i].pin;
                  2'b10: d.ch[i].pin = 1'b0;
                  2'b11: d.ch[i].pin = 1'b1;
                  default: d.ch[i].pin = d.ch[i].pin;
               endcase
            end
         end
      end

      // Registered outputs
      d.awready = !d.aw_full;
      d.wready = !d.w_full;
      d.arready = !d.rvalid;
      d.irq = (d.ovf_flag && d.ovf_ie) || (d.ch[0].flag && d.ch[0].irq_en)
              || (d.ch[1].flag && d.ch[1].irq_en && !d.ch[0].buf_mode);
      d.pin_out = {d.ch[1].pin, d.ch[0].pin};
      d.pin_oe[0] = (d.ch[0].mode_a || d.ch[0].buf_mode) && (d.ch[0].act_hi || d.ch[0].act_lo);
      d.pin_oe[1] = d.ch[1].mode_a && !d.ch[0].buf_mode
                    && (d.ch[1].act_hi || d.ch[1].act_lo);
      d.ext_in = d.ps == timer_pkg::PS_EXT;
   end

   // State register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.modulo <= timer_pkg::MODULO_RST;
         q.stop <= timer_pkg::STOP_RST;
         q.awready <= 1'b1;
         q.wready <= 1'b1;
         q.arready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign awready = q.awready;
   assign wready = q.wready;
   assign bresp = q.bresp;
   assign bvalid = q.bvalid;
   assign arready = q.arready;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign rvalid = q.rvalid;
   assign chan0_pin_out = q.pin_out[0];
   assign chan0_pin_oe = q.pin_oe[0];
   assign chan1_pin_out = q.pin_out[1];
   assign chan1_pin_oe = q.pin_oe[1];
   assign ext_clock_as_input = q.ext_in;
   assign irq_request = q.irq;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_cmp_at_match: assert property (cmp_ev[0] |=> (q.cnt == $past(act_val0) && q.ch[0].flag))
      else $error("Channel 0 compare off its value");
   chk_ovf_wrap_zero: assert property (ovf_ev |=> (q.cnt == 16'h0000 && q.ovf_flag))
      else $error("Overflow without wrap to zero or flag");
   chk_link_release: assert property (linked |=> !chan1_pin_oe)
      else $error("Channel 1 pin still driven while linked");
   chk_zero_duty: assert property ((ovf_ev && !q.ch[0].tov && !q.ch[0].pin
                                   && !q.ch[0].act_lo && !q.ch[0].max_duty) |=> !q.ch[0].pin)
      else $error("Overflow toggled with toggle disabled");
   chk_full_duty: assert property ((q.ch[0].max_duty && q.ch[0].tov) |=>
                                   chan0_pin_out == !$past(q.ch[0].act_lo))
      else $error("Full duty output not held");
   chk_swap_on_ovf: assert property ((linked && ovf_ev) |=> q.active_sel == $past(q.pending_sel))
      else $error("Buffered pair not swapped at overflow");
   chk_break_freeze: assert property ((break_active && !trst_wr) |=> $stable(q.cnt))
      else $error("Counter moved during break");
   chk_stop_freeze: assert property ((stop_mode && !trst_wr) |=> $stable(q.cnt))
      else $error("Counter moved in stop mode");
   chk_unarmed_clear: assert property ((wr_do && q.awaddr == 8'h00 && q.ovf_flag
                                       && !q.ovf_armed) |=> q.ovf_flag)
      else $error("Overflow flag cleared without armed read");
   chk_wait_refuse: assert property ((wr_do && wait_mode) |=> bresp == 2'h2)
      else $error("Write accepted in wait mode");
   chk_ext_input: assert property ((q.ps == 3'h7) |-> ext_clock_as_input)
      else $error("External clock pin not forced to input");
   chk_irq_gate: assert property ((q.ovf_flag && !q.ovf_ie && !q.ch[0].irq_en && !q.ch[1].irq_en)
                                  |-> !irq_request)
      else $error("Interrupt requested while disabled");

endmodule // two_channel_timer_pwm

// >>> tb/pin_partner.sv
// External clock source and channel pin drivers facing the timer
`timescale 1ns/1ps
module pin_partner (
   input wire logic aclk,
   input wire logic run,
   output logic ext_timer_clock_pin,
   output logic chan0_pin_in,
   output logic chan1_pin_in
);
   logic [1:0] div_q;
   // Start levels of the pins
   initial begin
      div_q = 2'h0;
      ext_timer_clock_pin = 1'b0;
      chan0_pin_in = 1'b0;
      chan1_pin_in = 1'b1;
   end
   // Slow pin clock, only while run is high, well below half the bus rate
   always @(posedge aclk) begin
      if (run) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) ext_timer_clock_pin <= !ext_timer_clock_pin;
      end
   end
   // Capture pins change every cycle so no stale level lingers
   always @(posedge aclk) begin
      chan0_pin_in <= !chan0_pin_in;
      chan1_pin_in <= !chan1_pin_in;
   end
endmodule // pin_partner

// >>> tb/test_two_channel_timer_pwm.sv
// Self-checking bench for the two-channel timer PWM block
`timescale 1ns/1ps
module test_two_channel_timer_pwm;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, wait_mode, stop_mode, break_active;
   logic ext_timer_clock_pin, chan0_pin_in, chan0_pin_out, chan0_pin_oe, chan1_pin_in;
   logic chan1_pin_out, chan1_pin_oe, ext_clock_as_input, irq_request, ext_run;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_q, seed, snap, hi;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] ctl_tab [3] = '{8'h1a, 8'h1b, 8'h18};
   int fails, cmp_count, k;

   two_channel_timer_pwm dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .wait_mode, .stop_mode, .break_active, .ext_timer_clock_pin,
      .chan0_pin_in, .chan0_pin_out, .chan0_pin_oe, .chan1_pin_in, .chan1_pin_out,
      .chan1_pin_oe, .ext_clock_as_input, .irq_request);
   pin_partner partner (.aclk, .run(ext_run), .ext_timer_clock_pin, .chan0_pin_in,
      .chan1_pin_in);

   // Pseudo-random source and expected high time over two periods
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] duty(input logic [7:0] ctl, input int w);
      return ctl[1] ? 32'(ctl[0] ? 20 : 2 * w) : 32'h0000_0000;
   endfunction

   // Verdict and run end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 50) begin
         fails++;
         $display("[FAIL] %0t bus answer never came", $time);
         end_sim();
      end
   endtask

   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      resp = bresp;
      tmo(i);
   endtask
   // Bus read, data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd_q = rdata;
      resp = rresp;
      tmo(i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_q, exp);
   endtask
   // Counts high cycles of the channel 0 pin over two periods
   task automatic measure();
      hi = 32'h0000_0000;
      repeat (30) @(posedge aclk);
      repeat (20) begin
         @(posedge aclk);
         hi = hi + {31'h0000_0000, chan0_pin_out};
      end
   endtask

   // Bus clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = !aclk;
   end
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, wait_mode} = '0;
      {stop_mode, break_active, ext_run} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      fails = 0;
      cmp_count = 0;
      seed = 32'h7878_233d;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(8'h00, 32'h0000_0020);
      rdchk(8'h08, 32'h0000_ffff);
      rdchk(8'h04, 32'h0000_0000);
      rd(8'hfc);
      chk(resp, timer_pkg::RESP_SLVERR);
      repeat (4) begin
         seed = lfsr(seed);
         wr(8'h18, seed);
         rdchk(8'h18, {16'h0000, seed[15:0]});
      end
      wr(8'h00, 32'h0000_0030);
      wr(8'h08, 32'h0000_0009);
      wr(8'h10, 32'h0000_0004);
      wr(8'h00, 32'h0000_0000);
      for (k = 0; k < 3; k++) begin
         wr(8'h0c, {24'h00_0000, ctl_tab[k]});
         measure();
         chk(hi, duty(ctl_tab[k], 4));
      end
      // Channel 1 as a set-on-compare output before the pair is linked
      wr(8'h18, 32'h0000_0002);
      wr(8'h14, 32'h0000_001c);
      repeat (12) @(posedge aclk);
      chk({chan1_pin_oe, chan1_pin_out}, 2'b11);
      wr(8'h0c, 32'h0000_003a);
      wr(8'h18, 32'h0000_0002);
      measure();
      chk(hi, duty(8'h3a, 2));
      chk(chan1_pin_oe, 1'b0);
      chk(chan0_pin_oe, 1'b1);
      wr(8'h00, 32'h0000_0020);
      rdchk(8'h00, 32'h0000_00a0);
      wr(8'h00, 32'h0000_0020);
      rdchk(8'h00, 32'h0000_0020);
      chk(irq_request, 1'b0);
      wr(8'h00, 32'h0000_0040);
      for (k = 0; k < 30 && irq_request !== 1'b1; k++) @(posedge aclk);
      chk(irq_request, 1'b1);
      wait_mode <= 1'b1;
      rd(8'h00);
      chk(resp, timer_pkg::RESP_SLVERR);
      chk(irq_request, 1'b1);
      wr(8'h08, 32'h0000_0003);
      chk(resp, timer_pkg::RESP_SLVERR);
      wait_mode <= 1'b0;
      rdchk(8'h08, 32'h0000_0009);
      for (k = 0; k < 2; k++) begin
         stop_mode <= (k == 0);
         break_active <= (k == 1);
         rd(8'h04);
         snap = rd_q;
         repeat (15) @(posedge aclk);
         rdchk(8'h04, snap);
      end
      break_active <= 1'b0;
      wr(8'h00, 32'h0000_0007);
      chk(ext_clock_as_input, 1'b1);
      rd(8'h04);
      snap = rd_q;
      repeat (15) @(posedge aclk);
      rdchk(8'h04, snap);
      ext_run <= 1'b1;
      repeat (40) @(posedge aclk);
      rd(8'h04);
      chk(rd_q !== snap, 1'b1);
      // Divide by two: sixteen bus cycles between samples give eight ticks
      wr(8'h00, 32'h0000_0001);
      rd(8'h04);
      snap = rd_q;
      repeat (13) @(posedge aclk);
      rdchk(8'h04, (snap + 32'h0000_0008) % 32'h0000_000a);
      end_sim();
   end
endmodule // test_two_channel_timer_pwm
